// ---- rtl/zas_pkg.sv ----
package zas_pkg;
  // Table sizes
  localparam int ZONES = 500;
  localparam int ZW = 9;
  localparam int DETS = 60;
  localparam int DW = 6;
  localparam int LOOPS = 4;
  localparam int LW = 2;
  localparam int ADDRS = 125;
  localparam int AW = 7;
  localparam int TW = 16;
  localparam int CW = 12;
  localparam int NOUT = 4;
  localparam int NMO = 2;
  localparam int CNTW = 10;
  // Timing
  localparam longint CLK_HZ = 200000000;
  localparam longint TICK_S = 1;
  localparam longint TICK_CYC = TICK_S * CLK_HZ;
  localparam int TEST_S = 60;
  localparam logic [5:0] TEST_TICKS = 6'(TEST_S);
  // Event kinds
  localparam logic [1:0] EV_AUTO = 2'h0;
  localparam logic [1:0] EV_MANUAL = 2'h1;
  localparam logic [1:0] EV_INSPECT = 2'h2;
  localparam logic [1:0] EV_CLEAR = 2'h3;
  // Zone fire state
  typedef enum logic [1:0] {ZS_IDLE, ZS_STAGE1, ZS_STAGE2} zas_zone_type;
endpackage : zas_pkg

// ---- rtl/zas_zone_ctrl.sv ----
`timescale 1ns/10ps
// Contract
// RULE1: Automatic detector in enabled zone puts zone in stage one until timer expires.
// RULE2: Stage two on stage-one expiry or at once on a manual call point.
// RULE3: Stage-one time configurable per zone; remaining time shown for display.
// RULE4: Inspection request in stage one adds zone's inspection time to remaining time.
// RULE5: Coincidence zone enters stage one only after two distinct automatic detectors.
// RULE6: Zone in test has alarmed detectors commanded clear every 60 s.
// RULE7: Test zone events not logged, drive no outputs or signalling; test indication only.
// RULE8: Disabled zone ignores activations and faults; common disabled indication given.
// RULE9: Disabled output held inactive and excluded from fault supervision.
// RULE10: Disabled detector treated as switched off: alarms and faults ignored.
// RULE11: Loop current above its upper threshold flags non-fatal short circuit.
// RULE12: Loop or monitored output current below lower threshold flags non-fatal interruption.
// RULE13: Monitored output current above threshold flags non-fatal short circuit.
// RULE14: Each output driven from chosen zones, separate stage-one and stage-two selections.
// RULE15: Non-fatal fault keeps operation, asserts light, sounder and fault message.
// RULE16: Fatal fault stops operation, asserts light, sounder and fault message.
// RULE17: Battery fully discharged during mains loss is a fatal fault.
// RULE18: Switched-off addresses are skipped during loop address assignment.
// RULE19: Up to 500 zones, each with up to 60 detectors from any loop.
// RULE20: Four loops, each with up to 125 addressable devices.
// RULE21: Device no longer answering raises non-fatal removed-device fault.
// RULE22: Leakage to ground reported as non-fatal ground fault.
// RULE23: Stage-one timer counts down once per second, stage two at zero.
module zas_zone_ctrl #(
  parameter longint TICK_CYCLES = zas_pkg::TICK_CYC
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Loop events
  input wire logic ev_valid,
  input wire logic [1:0] ev_kind,
  input wire logic [zas_pkg::ZW-1:0] ev_zone,
  input wire logic [zas_pkg::DW-1:0] ev_det,
  input wire logic [zas_pkg::LW-1:0] ev_loop,
  input wire logic [zas_pkg::AW-1:0] ev_addr,
  output logic ev_ready,
  // Zone configuration
  input wire logic zcfg_we,
  input wire logic [zas_pkg::ZW-1:0] zcfg_zone,
  input wire logic [zas_pkg::TW-1:0] zcfg_stage1,
  input wire logic [zas_pkg::TW-1:0] zcfg_inspect,
  input wire logic zcfg_coinc,
  input wire logic zcfg_test,
  input wire logic zcfg_disable,
  // Device configuration
  input wire logic dcfg_we,
  input wire logic [zas_pkg::LW-1:0] dcfg_loop,
  input wire logic [zas_pkg::AW-1:0] dcfg_addr,
  input wire logic dcfg_disable,
  input wire logic dcfg_off,
  // Address assignment query
  input wire logic [zas_pkg::LW-1:0] init_loop,
  input wire logic [zas_pkg::AW-1:0] init_addr,
  output logic init_skip,
  // Display
  input wire logic [zas_pkg::ZW-1:0] disp_zone,
  output logic [zas_pkg::TW-1:0] disp_remaining,
  // Associated outputs
  input wire logic [zas_pkg::NOUT-1:0][zas_pkg::ZW-1:0] out_sel1,
  input wire logic [zas_pkg::NOUT-1:0][zas_pkg::ZW-1:0] out_sel2,
  input wire logic [zas_pkg::NOUT-1:0] out_disable,
  output logic [zas_pkg::NOUT-1:0] out_active,
  // Currents and thresholds
  input wire logic [zas_pkg::LOOPS-1:0][zas_pkg::CW-1:0] loop_cur,
  input wire logic [zas_pkg::LOOPS-1:0][zas_pkg::CW-1:0] loop_hi,
  input wire logic [zas_pkg::LOOPS-1:0][zas_pkg::CW-1:0] loop_lo,
  input wire logic [zas_pkg::NMO-1:0][zas_pkg::CW-1:0] mo_cur,
  input wire logic [zas_pkg::NMO-1:0][zas_pkg::CW-1:0] mo_hi,
  input wire logic [zas_pkg::NMO-1:0][zas_pkg::CW-1:0] mo_lo,
  // Other fault sources
  input wire logic rm_valid,
  input wire logic [zas_pkg::ZW-1:0] rm_zone,
  input wire logic [zas_pkg::LW-1:0] rm_loop,
  input wire logic [zas_pkg::AW-1:0] rm_addr,
  input wire logic fault_ack,
  input wire logic ground_leak,
  input wire logic mains_fail,
  input wire logic battery_empty,
  input wire logic system_error,
  // Indications
  output logic [zas_pkg::LOOPS-1:0] loop_short,
  output logic [zas_pkg::LOOPS-1:0] loop_open,
  output logic [zas_pkg::NMO-1:0] mo_short,
  output logic [zas_pkg::NMO-1:0] mo_open,
  output logic removed_fault,
  output logic ground_fault,
  output logic nonfatal_fault,
  output logic fatal_fault,
  output logic fire_ind,
  output logic test_ind,
  output logic disabled_ind,
  output logic sounder,
  // Archive and detector clear command
  output logic log_valid,
  output logic [zas_pkg::ZW-1:0] log_zone,
  output logic [1:0] log_stage,
  output logic clr_valid,
  output logic [zas_pkg::ZW-1:0] clr_zone
);
  // Per-zone and per-device tables
  zas_pkg::zas_zone_type zst [zas_pkg::ZONES];
  logic [zas_pkg::TW-1:0] ztmr [zas_pkg::ZONES];
  logic [zas_pkg::TW-1:0] zs1 [zas_pkg::ZONES];
  logic [zas_pkg::TW-1:0] zinsp [zas_pkg::ZONES];
  logic [zas_pkg::DW-1:0] zfirst [zas_pkg::ZONES];
  logic zhave [zas_pkg::ZONES];
  logic zco [zas_pkg::ZONES];
  logic ztest [zas_pkg::ZONES];
  logic zdis [zas_pkg::ZONES];
  logic ddis [zas_pkg::LOOPS][128];
  logic doff [zas_pkg::LOOPS][128];
  // Control state
  logic [31:0] tick_cnt, next_tick_cnt;
  logic [5:0] test_cnt, next_test_cnt;
  logic sweep, next_sweep, test_due, next_test_due;
  logic [zas_pkg::ZW-1:0] ptr, next_ptr;
  logic [zas_pkg::CNTW-1:0] fire_n, next_fire_n, dis_n, next_dis_n, test_n, next_test_n;
  logic next_ev_ready, next_log_valid, next_clr_valid, next_removed, next_fatal;
  logic [1:0] next_log_stage;
  // Table write port
  logic wr_en;
  logic [zas_pkg::ZW-1:0] z;
  zas_pkg::zas_zone_type w_st;
  logic [zas_pkg::TW-1:0] w_tmr;
  logic [zas_pkg::DW-1:0] w_first;
  logic w_have, take, valid_ev;
  logic [zas_pkg::NOUT-1:0] next_out;
  logic [zas_pkg::LOOPS-1:0] next_lshort, next_lopen;
  logic [zas_pkg::NMO-1:0] next_mshort, next_mopen;

  // One-second tick and 60 s test period
  always_comb begin
    next_tick_cnt = tick_cnt + 32'h1;
    next_test_cnt = test_cnt;
    next_test_due = test_due;
    next_sweep = sweep;
    next_ptr = ptr;
    if (tick_cnt == 32'(TICK_CYCLES - 1)) begin
      next_tick_cnt = 32'h0;
      if (!fatal_fault) begin
        next_sweep = 1'b1; // [RULE23]
        next_ptr = '0;
        next_test_cnt = test_cnt + 6'h1;
        if (test_cnt == zas_pkg::TEST_TICKS - 6'h1) begin
          next_test_cnt = 6'h0;
          next_test_due = 1'b1; // [RULE6]
        end
      end
    end else if (sweep) begin
      next_ptr = ptr + 9'h1;
      if (ptr == 9'(zas_pkg::ZONES - 1)) begin
        next_sweep = 1'b0;
        next_test_due = 1'b0;
      end
    end
    next_ev_ready = !next_sweep && !next_fatal; // [RULE16]
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      tick_cnt <= 32'h0;
      test_cnt <= 6'h0;
      test_due <= 1'b0;
      sweep <= 1'b0;
      ptr <= '0;
      ev_ready <= 1'b0;
    end else begin
      tick_cnt <= next_tick_cnt;
      test_cnt <= next_test_cnt;
      test_due <= next_test_due;
      sweep <= next_sweep;
      ptr <= next_ptr;
      ev_ready <= next_ev_ready;
    end
  end

  // Zone sequencing: sweep decrements timers, otherwise one event per cycle
  assign take = ev_valid && ev_ready;
  assign valid_ev = ev_zone < 9'(zas_pkg::ZONES) && ev_det < 6'(zas_pkg::DETS)
    && ev_addr < 7'(zas_pkg::ADDRS) && !zdis[ev_zone] && !ddis[ev_loop][ev_addr]; // [RULE19] [RULE20] [RULE8] [RULE10]
  assign z = sweep ? ptr : ev_zone;
  always_comb begin
    wr_en = 1'b0;
    w_st = zst[z];
    w_tmr = ztmr[z];
    w_first = zfirst[z];
    w_have = zhave[z];
    next_fire_n = fire_n;
    next_log_valid = 1'b0;
    next_log_stage = 2'h0;
    next_clr_valid = 1'b0;
    if (sweep) begin
      wr_en = 1'b1;
      if (zst[z] == zas_pkg::ZS_STAGE1) begin
        w_tmr = ztmr[z] - 16'h1; // [RULE23]
        if (ztmr[z] <= 16'h1) begin
          w_tmr = 16'h0;
          w_st = zas_pkg::ZS_STAGE2; // [RULE2]
          next_log_valid = !ztest[z];
          next_log_stage = 2'h2;
        end
      end
      if (test_due && ztest[z] && (zst[z] != zas_pkg::ZS_IDLE || zhave[z])) begin
        w_st = zas_pkg::ZS_IDLE; // [RULE6]
        w_have = 1'b0;
        w_tmr = 16'h0;
        next_clr_valid = 1'b1;
      end
    end else if (take && valid_ev) begin
      wr_en = 1'b1;
      case (ev_kind)
        zas_pkg::EV_AUTO: begin
          if (zst[z] == zas_pkg::ZS_IDLE) begin
            if (zco[z] && !(zhave[z] && zfirst[z] != ev_det)) begin
              w_have = 1'b1; // [RULE5]
              w_first = ev_det;
            end else begin
              w_st = zas_pkg::ZS_STAGE1; // [RULE1]
              w_tmr = zs1[z]; // [RULE3]
              next_log_valid = !ztest[z];
              next_log_stage = 2'h1;
            end
          end
        end
        zas_pkg::EV_MANUAL: begin
          if (zst[z] != zas_pkg::ZS_STAGE2) begin
            w_st = zas_pkg::ZS_STAGE2; // [RULE2]
            w_tmr = 16'h0;
            next_log_valid = !ztest[z];
            next_log_stage = 2'h2;
          end
        end
        zas_pkg::EV_INSPECT: begin
          if (zst[z] == zas_pkg::ZS_STAGE1) begin
            w_tmr = ztmr[z] + zinsp[z]; // [RULE4]
          end
        end
        default: begin
          w_st = zas_pkg::ZS_IDLE;
          w_have = 1'b0;
          w_tmr = 16'h0;
        end
      endcase
    end
    // Fire indication counts only zones not in test
    if (wr_en && !ztest[z]) begin // [RULE7]
      if (zst[z] == zas_pkg::ZS_IDLE && w_st != zas_pkg::ZS_IDLE) begin
        next_fire_n = fire_n + 10'h1;
      end else if (zst[z] != zas_pkg::ZS_IDLE && w_st == zas_pkg::ZS_IDLE && fire_n != 10'h0) begin
        next_fire_n = fire_n - 10'h1;
      end
    end
  end

  // Configuration bookkeeping for common indications
  always_comb begin
    next_dis_n = dis_n;
    next_test_n = test_n;
    if (zcfg_we && zcfg_zone < 9'(zas_pkg::ZONES)) begin
      next_dis_n = dis_n + 10'(zcfg_disable) - 10'(zdis[zcfg_zone]);
      next_test_n = test_n + 10'(zcfg_test) - 10'(ztest[zcfg_zone]);
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      for (int i = 0; i < zas_pkg::ZONES; i++) begin
        zst[i] <= zas_pkg::ZS_IDLE;
        ztmr[i] <= 16'h0;
        zhave[i] <= 1'b0;
        zfirst[i] <= 6'h0;
        zs1[i] <= 16'h0;
        zinsp[i] <= 16'h0;
        zco[i] <= 1'b0;
        ztest[i] <= 1'b0;
        zdis[i] <= 1'b0;
      end
      for (int l = 0; l < zas_pkg::LOOPS; l++) begin
        for (int a = 0; a < 128; a++) begin
          ddis[l][a] <= 1'b0;
          doff[l][a] <= 1'b0;
        end
      end
    end else begin
      if (wr_en) begin
        zst[z] <= w_st;
        ztmr[z] <= w_tmr;
        zhave[z] <= w_have;
        zfirst[z] <= w_first;
      end
      if (zcfg_we && zcfg_zone < 9'(zas_pkg::ZONES)) begin
        zs1[zcfg_zone] <= zcfg_stage1; // [RULE3]
        zinsp[zcfg_zone] <= zcfg_inspect;
        zco[zcfg_zone] <= zcfg_coinc;
        ztest[zcfg_zone] <= zcfg_test;
        zdis[zcfg_zone] <= zcfg_disable;
      end
      if (dcfg_we) begin
        ddis[dcfg_loop][dcfg_addr] <= dcfg_disable;
        doff[dcfg_loop][dcfg_addr] <= dcfg_off;
      end
    end
  end

  // Associated outputs and current supervision
  for (genvar i = 0; i < zas_pkg::NOUT; i++) begin : g_out
    assign next_out[i] = !out_disable[i] && !fatal_fault
      && ((out_sel1[i] < 9'(zas_pkg::ZONES) && zst[out_sel1[i]] != zas_pkg::ZS_IDLE && !ztest[out_sel1[i]])
      || (out_sel2[i] < 9'(zas_pkg::ZONES) && zst[out_sel2[i]] == zas_pkg::ZS_STAGE2
      && !ztest[out_sel2[i]])); // [RULE14] [RULE9] [RULE7]
  end
  for (genvar i = 0; i < zas_pkg::LOOPS; i++) begin : g_loop
    assign next_lshort[i] = loop_cur[i] > loop_hi[i]; // [RULE11]
    assign next_lopen[i] = loop_cur[i] < loop_lo[i]; // [RULE12]
  end
  for (genvar i = 0; i < zas_pkg::NMO; i++) begin : g_mo
    assign next_mshort[i] = !out_disable[i] && mo_cur[i] > mo_hi[i]; // [RULE13] [RULE9]
    assign next_mopen[i] = !out_disable[i] && mo_cur[i] < mo_lo[i]; // [RULE12] [RULE9]
  end

  // Removed device is sticky; a new removal wins over the acknowledge
  assign next_removed = (rm_valid && rm_zone < 9'(zas_pkg::ZONES) && !zdis[rm_zone]
    && !ddis[rm_loop][rm_addr]) || (removed_fault && !fault_ack); // [RULE21] [RULE8] [RULE10]
  assign next_fatal = fatal_fault || (battery_empty && mains_fail) || system_error; // [RULE17] [RULE16]

  // Registered indications
  always_ff @(posedge clock) begin
    if (rst) begin
      fire_n <= 10'h0;
      dis_n <= 10'h0;
      test_n <= 10'h0;
      out_active <= '0;
      loop_short <= '0;
      loop_open <= '0;
      mo_short <= '0;
      mo_open <= '0;
      removed_fault <= 1'b0;
      ground_fault <= 1'b0;
      nonfatal_fault <= 1'b0;
      fatal_fault <= 1'b0;
      fire_ind <= 1'b0;
      test_ind <= 1'b0;
      disabled_ind <= 1'b0;
      sounder <= 1'b0;
      init_skip <= 1'b0;
      disp_remaining <= 16'h0;
      log_valid <= 1'b0;
      log_zone <= '0;
      log_stage <= 2'h0;
      clr_valid <= 1'b0;
      clr_zone <= '0;
    end else begin
      fire_n <= next_fire_n;
      dis_n <= next_dis_n;
      test_n <= next_test_n;
      out_active <= next_out;
      loop_short <= next_lshort;
      loop_open <= next_lopen;
      mo_short <= next_mshort;
      mo_open <= next_mopen;
      removed_fault <= next_removed;
      ground_fault <= ground_leak; // [RULE22]
      nonfatal_fault <= |{next_lshort, next_lopen, next_mshort, next_mopen, next_removed, ground_leak}; // [RULE15]
      fatal_fault <= next_fatal;
      fire_ind <= next_fire_n != 10'h0;
      test_ind <= next_test_n != 10'h0; // [RULE7]
      disabled_ind <= next_dis_n != 10'h0 || |out_disable; // [RULE8] [RULE9]
      sounder <= next_fire_n != 10'h0 || next_fatal || |{next_lshort, next_lopen, next_mshort,
        next_mopen, next_removed, ground_leak}; // [RULE15] [RULE16]
      init_skip <= doff[init_loop][init_addr]; // [RULE18]
      disp_remaining <= zst[disp_zone] == zas_pkg::ZS_STAGE1 ? ztmr[disp_zone] : 16'h0; // [RULE3]
      log_valid <= next_log_valid; // [RULE7]
      log_zone <= z;
      log_stage <= next_log_stage;
      clr_valid <= next_clr_valid;
      clr_zone <= z;
    end
  end
endmodule : zas_zone_ctrl

// ---- verification/zas_zone_monitor.sv ----
`timescale 1ns/10ps
module zas_zone_monitor (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Watched inputs
  input wire logic [zas_pkg::LOOPS-1:0][zas_pkg::CW-1:0] loop_cur,
  input wire logic [zas_pkg::LOOPS-1:0][zas_pkg::CW-1:0] loop_hi,
  input wire logic [zas_pkg::LOOPS-1:0][zas_pkg::CW-1:0] loop_lo,
  input wire logic [zas_pkg::NMO-1:0][zas_pkg::CW-1:0] mo_cur,
  input wire logic [zas_pkg::NMO-1:0][zas_pkg::CW-1:0] mo_hi,
  input wire logic [zas_pkg::NOUT-1:0] out_disable,
  input wire logic ground_leak,
  input wire logic mains_fail,
  input wire logic battery_empty,
  // Watched outputs
  input logic ev_ready,
  input logic [zas_pkg::NOUT-1:0] out_active,
  input logic [zas_pkg::LOOPS-1:0] loop_short,
  input logic [zas_pkg::LOOPS-1:0] loop_open,
  input logic [zas_pkg::NMO-1:0] mo_short,
  input logic ground_fault,
  input logic nonfatal_fault,
  input logic fatal_fault,
  input logic test_ind,
  input logic sounder,
  input logic log_valid,
  input logic [1:0] log_stage,
  input logic clr_valid
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);
  // Fault classification
  chk_fatal_latch: assert property (fatal_fault |=> fatal_fault)
    else $error("fatal fault dropped");
  chk_fatal_stops: assert property (fatal_fault |=> !ev_ready)
    else $error("events taken after fatal fault");
  chk_battery_fatal: assert property (mains_fail && battery_empty |-> ##[1:2] fatal_fault)
    else $error("battery loss not fatal");
  chk_loop_short: assert property (!$past(rst) |-> loop_short[0] == $past(loop_cur[0] > loop_hi[0]))
    else $error("loop short flag wrong");
  chk_loop_open: assert property (!$past(rst) |-> loop_open[1] == $past(loop_cur[1] < loop_lo[1]))
    else $error("loop open flag wrong");
  chk_mo_short: assert property (!$past(rst) |-> mo_short[0] == $past(mo_cur[0] > mo_hi[0] && !out_disable[0]))
    else $error("output short flag wrong");
  chk_out_disabled: assert property (out_disable[0] [*3] |-> !out_active[0])
    else $error("disabled output active");
  chk_ground_fault: assert property (ground_leak [*3] |-> ground_fault)
    else $error("ground fault missing");
  chk_fault_sounder: assert property ($rose(nonfatal_fault) |-> ##[0:1] sounder)
    else $error("sounder silent on fault");
  chk_test_clear: assert property (clr_valid |-> test_ind)
    else $error("clear outside test");
  chk_log_stage: assert property (log_valid |-> log_stage inside {2'h1, 2'h2})
    else $error("bad logged stage");
  // Main scenarios reached
  cover property (log_valid && log_stage == 2'h2);
  cover property (clr_valid);
  cover property (fatal_fault);
endmodule : zas_zone_monitor
bind zas_zone_ctrl zas_zone_monitor mon (.*);

// ---- verification/zas_loop_model.sv ----
`timescale 1ns/10ps
module zas_loop_model (
  // Clock
  input wire logic clock,
  // Event request
  output logic ev_valid,
  output logic [1:0] ev_kind,
  output logic [8:0] ev_zone,
  output logic [5:0] ev_det,
  output logic [1:0] ev_loop,
  output logic [6:0] ev_addr,
  input wire logic ev_ready,
  // Clear command
  input wire logic clr_valid,
  input wire logic [8:0] clr_zone
);
  logic [499:0] alarmed = '0;
  // Idle request lines
  initial begin
    ev_valid = 1'b0;
    {ev_kind, ev_zone, ev_det, ev_loop, ev_addr} = '0;
  end
  // Detectors in alarm drop their state on a clear command
  always @(posedge clock) if (clr_valid) alarmed[clr_zone] <= 1'b0;
  // One request, held until the panel takes it
  task automatic send(input logic [1:0] k, input logic [8:0] z, input logic [5:0] d,
                      input logic [1:0] l, input logic [6:0] a);
    @(negedge clock);
    ev_valid = 1'b1;
    {ev_kind, ev_zone, ev_det, ev_loop, ev_addr} = {k, z, d, l, a};
    do @(posedge clock); while (!ev_ready);
    if (k == 2'h0 && z < 9'h1F4) alarmed[z] <= 1'b1;
    @(negedge clock);
    ev_valid = 1'b0;
    // Released lines no longer show the last request
    {ev_kind, ev_zone, ev_det, ev_loop, ev_addr} = ~{k, z, d, l, a};
  endtask : send
endmodule : zas_loop_model

// ---- verification/tb_top.sv ----
`timescale 1ns/10ps
module tb_top;
  localparam int TK = 600;
  typedef struct packed {logic [11:0] cur; logic [11:0] hi; logic [11:0] lo; logic sh; logic op;} zas_row_type;
  localparam zas_row_type ROWS [4] = '{'{12'h0C8, 12'h0C7, 12'h010, 1'b1, 1'b0},
    '{12'h0C8, 12'h0C8, 12'h010, 1'b0, 1'b0}, '{12'h00F, 12'h0C8, 12'h010, 1'b0, 1'b1},
    '{12'h010, 12'h0C8, 12'h010, 1'b0, 1'b0}};
  // Clock, stimulus and observed ports
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic ev_valid, ev_ready, zcfg_we, zcfg_coinc, zcfg_test, zcfg_disable, dcfg_we, dcfg_disable, dcfg_off;
  logic rm_valid, fault_ack, ground_leak, mains_fail, battery_empty, system_error, init_skip;
  logic removed_fault, ground_fault, nonfatal_fault, fatal_fault, fire_ind, test_ind, disabled_ind;
  logic sounder, log_valid, clr_valid;
  logic [1:0] ev_kind, log_stage, ev_loop, dcfg_loop, init_loop, rm_loop, mo_short, mo_open;
  logic [8:0] ev_zone, zcfg_zone, disp_zone, rm_zone, log_zone, clr_zone;
  logic [5:0] ev_det;
  logic [6:0] ev_addr, dcfg_addr, init_addr, rm_addr;
  logic [15:0] zcfg_stage1, zcfg_inspect, disp_remaining;
  logic [3:0][8:0] out_sel1, out_sel2;
  logic [3:0] out_disable, out_active, loop_short, loop_open;
  logic [3:0][11:0] loop_cur, loop_hi, loop_lo;
  logic [1:0][11:0] mo_cur, mo_hi, mo_lo;
  int failures = 0;
  int cmp_count = 0;
  int n;
  always #2.5 clock = ~clock;
  zas_zone_ctrl #(.TICK_CYCLES(TK)) dut (.*);
  zas_loop_model loop_dev (.*);
  // Compare and count
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic tick(input int c);
    repeat (c) @(negedge clock);
  endtask : tick
  // Zone and device table writes
  task automatic zc(input logic [8:0] z, input logic [15:0] s1, input logic [15:0] ins, input logic [2:0] m);
    @(negedge clock);
    zcfg_we = 1'b1;
    {zcfg_zone, zcfg_stage1, zcfg_inspect, zcfg_coinc, zcfg_test, zcfg_disable} = {z, s1, ins, m};
    @(negedge clock);
    zcfg_we = 1'b0;
  endtask : zc
  task automatic dc(input logic [1:0] l, input logic [6:0] a, input logic [1:0] m);
    @(negedge clock);
    dcfg_we = 1'b1;
    {dcfg_loop, dcfg_addr, dcfg_disable, dcfg_off} = {l, a, m};
    @(negedge clock);
    dcfg_we = 1'b0;
  endtask : dc
  task automatic complete_run;
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : complete_run
  // Watchdog
  initial begin
    repeat (90000) @(posedge clock);
    failures++;
    complete_run;
  end
  // Main sequence
  initial begin
    {zcfg_we, zcfg_coinc, zcfg_test, zcfg_disable, dcfg_we, dcfg_disable, dcfg_off} = '0;
    {rm_valid, fault_ack, ground_leak, mains_fail, battery_empty, system_error} = '0;
    {zcfg_zone, zcfg_stage1, zcfg_inspect, dcfg_loop, dcfg_addr, init_loop, init_addr} = '0;
    {disp_zone, rm_zone, rm_loop, rm_addr, out_disable} = '0;
    out_sel1 = {4{9'h1FF}};
    out_sel2 = {9'h1FF, 9'h009, 9'h005, 9'h1FF};
    out_sel1[0] = 9'h005;
    loop_cur = {4{12'h064}};
    loop_hi = {4{12'h0C8}};
    loop_lo = {4{12'h032}};
    mo_cur = {2{12'h064}};
    mo_hi = {2{12'h0C8}};
    mo_lo = {2{12'h032}};
    repeat (8) @(negedge clock);
    rst = 1'b0;
    tick(1);
    chk(ev_ready, 1'b1);
    chk({fire_ind, sounder, out_active}, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      {loop_cur[i], loop_hi[i], loop_lo[i]} = {ROWS[i].cur, ROWS[i].hi, ROWS[i].lo};
    end
    tick(2);
    for (int i = 0; i < 4; i++) begin
      chk(loop_short[i], ROWS[i].sh);
      chk(loop_open[i], ROWS[i].op);
    end
    zc(9'h005, 16'h0002, 16'h0003, 3'b000);
    zc(9'h006, 16'h0002, 16'h0000, 3'b100);
    zc(9'h007, 16'h0002, 16'h0000, 3'b010);
    zc(9'h008, 16'h0002, 16'h0000, 3'b001);
    dc(2'h0, 7'h03, 2'b10);
    dc(2'h1, 7'h04, 2'b01);
    init_loop = 2'h1;
    init_addr = 7'h04;
    tick(1);
    chk(init_skip, 1'b1);
    chk(disabled_ind, 1'b1);
    chk(test_ind, 1'b1);
    init_addr = 7'h05;
    tick(1);
    chk(init_skip, 1'b0);
    loop_dev.send(2'h0, 9'h1F4, 6'h00, 2'h0, 7'h01);
    chk(log_valid, 1'b0);
    loop_dev.send(2'h0, 9'h00B, 6'h00, 2'h0, 7'h7D);
    chk(log_valid, 1'b0);
    loop_dev.send(2'h0, 9'h00A, 6'h00, 2'h0, 7'h03);
    chk(log_valid, 1'b0);
    loop_dev.send(2'h0, 9'h008, 6'h00, 2'h0, 7'h01);
    chk(log_valid, 1'b0);
    loop_dev.send(2'h0, 9'h007, 6'h00, 2'h0, 7'h01);
    chk(log_valid, 1'b0);
    loop_dev.send(2'h0, 9'h006, 6'h01, 2'h0, 7'h01);
    chk(log_valid, 1'b0);
    loop_dev.send(2'h0, 9'h006, 6'h01, 2'h0, 7'h01);
    chk(log_valid, 1'b0);
    loop_dev.send(2'h0, 9'h006, 6'h02, 2'h0, 7'h02);
    chk({log_valid, log_stage}, 16'h0005);
    disp_zone = 9'h005;
    loop_dev.send(2'h0, 9'h005, 6'h00, 2'h0, 7'h05);
    chk({log_valid, log_stage, log_zone}, 16'h0A05);
    tick(2);
    chk(disp_remaining, 16'h0002);
    chk({fire_ind, sounder, out_active[0]}, 16'h0007);
    loop_dev.send(2'h2, 9'h005, 6'h00, 2'h0, 7'h05);
    tick(2);
    chk(disp_remaining, 16'h0005);
    n = 0;
    while (!(log_valid && log_zone == 9'h005) && n < 8 * TK) begin
      tick(1);
      n++;
    end
    chk(log_stage, 2'h2);
    chk(n > 3 * TK && n < 6 * TK, 1'b1);
    tick(2);
    chk(out_active[1], 1'b1);
    loop_dev.send(2'h1, 9'h009, 6'h00, 2'h0, 7'h06);
    chk({log_valid, log_stage, log_zone}, 16'h0C09);
    tick(2);
    chk(out_active[2], 1'b1);
    n = 0;
    while (!(clr_valid && clr_zone == 9'h007) && n < 62 * TK) begin
      tick(1);
      n++;
    end
    chk(n < 62 * TK, 1'b1);
    tick(1);
    chk(loop_dev.alarmed[7], 1'b0);
    mo_cur = {12'h00A, 12'h12C};
    tick(2);
    chk(mo_short[0], 1'b1);
    chk(mo_open[1], 1'b1);
    out_disable[0] = 1'b1;
    tick(3);
    chk({mo_short[0], out_active[0]}, 16'h0000);
    rm_valid = 1'b1;
    tick(1);
    rm_valid = 1'b0;
    tick(1);
    chk({removed_fault, nonfatal_fault, sounder}, 16'h0007);
    fault_ack = 1'b1;
    tick(1);
    fault_ack = 1'b0;
    tick(1);
    chk(removed_fault, 1'b0);
    ground_leak = 1'b1;
    tick(3);
    chk(ground_fault, 1'b1);
    {mains_fail, battery_empty} = 2'b11;
    tick(3);
    chk(fatal_fault, 1'b1);
    chk({ev_ready, sounder}, 16'h0001);
    complete_run;
  end
endmodule : tb_top
